// ===== bench/perf_host_model.sv
`timescale 1ns/1ps
`include "perf_regs.svh"
module perf_host_model (
  input wire logic ref_clk,
  output perf_pkg::range_mode_t mode,
  output perf_pkg::event_source_t source [`PERF_CHANNELS],
  output logic apply_setup,
  output logic init_request
);
  import perf_pkg::*;
  initial begin
    mode = MODE_NORMAL;
    source = '{default: SRC_DISABLED};
    apply_setup = 1'b0;
    init_request = 1'b0;
  end
  // Host offers no single-step request at all
  // Range setups normally name an enabled channel
  task automatic setup(input range_mode_t m,
    input event_source_t s [`PERF_CHANNELS]);
    @(negedge ref_clk);
    mode = m;
    source = s;
    apply_setup = 1'b1;
    @(negedge ref_clk);
    apply_setup = 1'b0;
    @(negedge ref_clk);
  endtask : setup
  task automatic init;
    @(negedge ref_clk);
    init_request = 1'b1;
    @(negedge ref_clk);
    init_request = 1'b0;
  endtask : init
endmodule : perf_host_model

// ===== bench/tb_perf_event_counters.sv
`timescale 1ns/1ps
`include "perf_regs.svh"
module tb_perf_event_counters;
  import perf_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  range_mode_t mode;
  event_source_t source [`PERF_CHANNELS];
  logic apply_setup;
  logic init_request;
  logic prog_running = 1'b0;
  logic break_hit = 1'b0;
  logic cond_one_match = 1'b0;
  logic cond_two_match = 1'b0;
  cpu_events_t cpu_events = '0;
  logic [`PERF_CNT_W-1:0] result [`PERF_CHANNELS];
  logic [`PERF_CHANNELS-1:0] overflow;
  logic setup_error;
  logic measuring;
  int mismatches = 0;
  int cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  perf_host_model u_perf_host_model (.ref_clk(ref_clk), .mode(mode),
    .source(source), .apply_setup(apply_setup),
    .init_request(init_request));
  perf_event_counters u_perf_event_counters (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .mode(mode), .source(source),
    .apply_setup(apply_setup), .init_request(init_request),
    .prog_running(prog_running), .break_hit(break_hit),
    .cond_one_match(cond_one_match), .cond_two_match(cond_two_match),
    .cpu_events(cpu_events), .result(result), .overflow(overflow),
    .setup_error(setup_error), .measuring(measuring));
  task automatic stop_test;
    $display("checks %0d bad %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] lo,
    input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic sig(input int s, input logic v);
    case (s)
      0: prog_running = v;
      1: cond_one_match = v;
      2: cond_two_match = v;
      default: break_hit = v;
    endcase
  endtask : sig
  // Open, repeat start, count n cycles, close, then poke while idle
  task automatic win(input int st, input int en, input cpu_events_t ev,
    input int n);
    int k;
    @(negedge ref_clk) sig(st, 1'b1);
    @(negedge ref_clk) sig(st, 1'(st == 0));
    @(negedge ref_clk) cpu_events = ev;
    sig(st, 1'b1);
    @(negedge ref_clk) sig(st, 1'(st == 0));
    repeat (n - 1) @(negedge ref_clk);
    cpu_events = '0;
    sig(en, 1'b1);
    sig(0, 1'b0);
    @(negedge ref_clk) sig(en, 1'b0);
    k = 0;
    while (measuring !== 1'b0 && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
    if (measuring !== 1'b0) begin
      mismatches++;
      $display("BAD %0t window never closed", $time);
      stop_test;
    end
    cpu_events = ev;
    sig(en, 1'b1);
    repeat (2) @(negedge ref_clk);
    cpu_events = '0;
    sig(en, 1'b0);
  endtask : win
  task automatic t_one_two;
    u_perf_host_model.setup(MODE_ONE_TO_TWO, '{SRC_BRANCH, SRC_ELAPSED,
      SRC_INSTR, SRC_DISABLED});
    chk(32'(setup_error), 0, 0);
    win(1, 2, 8'h60, 5);
    chk(result[0], 10, 10);
    chk(result[1], 6, 8);
    chk(result[2], 5, 5);
    chk(result[3], 0, 0);
    $display("done one_two");
  endtask : t_one_two
  task automatic t_two_one;
    u_perf_host_model.setup(MODE_TWO_TO_ONE, '{SRC_EXEC_STATES,
      SRC_INSTR_DATA_CONFLICT, SRC_OTHER_CONFLICT, SRC_DSP_INSTR});
    win(2, 1, 8'h98, 3);
    chk(result[0], 3, 3);
    chk(result[1], 3, 3);
    chk(result[2], 0, 0);
    chk(result[3], 3, 3);
    $display("done two_one");
  endtask : t_two_one
  task automatic t_normal;
    u_perf_host_model.setup(MODE_NORMAL, '{SRC_EXCEPTION, SRC_ELAPSED,
      SRC_DATA_TLB_MISS, SRC_DISABLED});
    win(0, 3, 8'h03, 4);
    chk(result[0], 4, 4);
    chk(result[1], 5, 7);
    chk(result[2], 4, 4);
    chk(32'(overflow), 0, 0);
    u_perf_host_model.init();
    for (int i = 0; i < 4; i++)
      chk(result[i], 0, 0);
    $display("done normal");
  endtask : t_normal
  task automatic t_error;
    u_perf_host_model.setup(MODE_ONE_TO_TWO, '{default: SRC_DISABLED});
    chk(32'(setup_error), 1, 1);
    @(negedge ref_clk) cond_one_match = 1'b1;
    @(negedge ref_clk) cond_one_match = 1'b0;
    @(negedge ref_clk);
    chk(32'(measuring), 0, 0);
    $display("done error");
  endtask : t_error
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk(result[0], 0, 0);
    chk(32'(measuring), 0, 0);
    t_one_two;
    t_two_one;
    t_normal;
    t_error;
    stop_test;
  end
endmodule : tb_perf_event_counters

// ===== include/perf_chan_if.sv
`timescale 1ns/1ps
`include "perf_regs.svh"
interface perf_chan_if;
  logic window;
  logic clear;
  logic [`PERF_CNT_W-1:0] step;
  logic [`PERF_CNT_W-1:0] count;
  logic overflow;
  modport ctrl (output window, output clear, output step,
    input count, input overflow);
  modport chan (input window, input clear, input step,
    output count, output overflow);
endinterface : perf_chan_if

// ===== include/perf_pkg.sv
`include "perf_regs.svh"
package perf_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ONE_TO_TWO = 2'b01,
    MODE_TWO_TO_ONE = 2'b10
  } range_mode_t;

  typedef enum logic [3:0] {
    SRC_DISABLED = 4'h0,
    SRC_ELAPSED = 4'h1,
    SRC_EXEC_STATES = 4'h2,
    SRC_BRANCH = 4'h3,
    SRC_INSTR = 4'h4,
    SRC_DSP_INSTR = 4'h5,
    SRC_INSTR_DATA_CONFLICT = 4'h6,
    SRC_OTHER_CONFLICT = 4'h7,
    SRC_EXCEPTION = 4'h8,
    SRC_DATA_TLB_MISS = 4'h9
  } event_source_t;

  typedef struct packed {
    logic exec_state;
    logic branch_taken;
    logic instr_done;
    logic dsp_instr_done;
    logic instr_data_conflict;
    logic other_conflict;
    logic exception_taken;
    logic data_tlb_miss;
  } cpu_events_t;
endpackage : perf_pkg

// ===== include/perf_regs.svh
// Behaviour
// - In the normal-break mode the window opens when the program starts running and closes at any break.
// - In the first-to-second mode a match of condition one opens the window and a later match of condition two closes it.
// - In the second-to-first mode a match of condition two opens the window and a later match of condition one closes it.
// - Four independent channels count at the same time over one shared window.
// - Each channel picks one source: disabled, elapsed time, execution states, branches, instructions, DSP instructions, exceptions, TLB misses or conflicts.
// - Conflict cycles from instruction/data accesses and from other accesses are separate sources.
// - The DSP instruction source works only when the device has DSP capability.
// - The data-TLB miss source works only when the device has a memory management unit.
// - Counts may be off near the window edges, so checks must allow some tolerance.
// - Each taken branch adds two to a branch counter.
// - The counters run on the CPU clock and stop whenever that clock stops.
// - Each channel gives a 32-bit result, and an overflow of it can be seen.
`ifndef PERF_REGS_SVH
`define PERF_REGS_SVH
`define PERF_CHANNELS 4
`define PERF_CNT_W 32
`define PERF_SRC_W 4
`define PERF_MODE_W 2
`define PERF_BRANCH_STEP 32'h0000_0002
`define PERF_ONE_STEP 32'h0000_0001
`define PERF_CNT_ZERO 32'h0000_0000
`endif

// ===== src/perf_channel.sv
`timescale 1ns/1ps
`include "perf_regs.svh"
module perf_channel (
  input wire logic ref_clk,
  input wire logic sys_rst,
  perf_chan_if.chan port
);
  import perf_pkg::*;
  logic [`PERF_CNT_W:0] sum;
  logic [`PERF_CNT_W-1:0] count;
  logic overflow;

  assign sum = {1'b0, count} + {1'b0, port.step};
  assign port.count = count;
  assign port.overflow = overflow;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || port.clear) begin
      count <= `PERF_CNT_ZERO;
      overflow <= 1'b0;
    end else if (port.window) begin
      count <= sum[`PERF_CNT_W-1:0];
      overflow <= overflow | sum[`PERF_CNT_W];
    end
  end

  clear_zero_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    port.clear |=> (count == `PERF_CNT_ZERO && !overflow))
    else $error("counter not cleared");
  hold_idle_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!port.window && !port.clear) |=> $stable(count))
    else $error("counter moved outside window");
  overflow_sticky_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (overflow && !port.clear) |=> overflow)
    else $error("overflow flag lost");
endmodule : perf_channel

// ===== src/perf_event_counters.sv
`timescale 1ns/1ps
`include "perf_regs.svh"
module perf_event_counters #(
  parameter bit HAS_DSP = 1'b1,
  parameter bit HAS_MMU = 1'b1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire perf_pkg::range_mode_t mode,
  input wire perf_pkg::event_source_t
    source [`PERF_CHANNELS],
  input wire logic apply_setup,
  input wire logic init_request,
  input wire logic prog_running,
  input wire logic break_hit,
  input wire logic cond_one_match,
  input wire logic cond_two_match,
  input wire perf_pkg::cpu_events_t cpu_events,
  output logic [`PERF_CNT_W-1:0] result [`PERF_CHANNELS],
  output logic [`PERF_CHANNELS-1:0] overflow,
  output logic setup_error,
  output logic measuring
);
  import perf_pkg::*;

  range_mode_t active_mode;
  event_source_t active_src [`PERF_CHANNELS];
  logic armed;
  logic window;
  logic any_enabled;
  logic start_hit;
  logic end_hit;
  logic next_window;
  logic setup_ok;

  function automatic logic [`PERF_CNT_W-1:0] step_of(
    input event_source_t src, input cpu_events_t ev);
    logic [`PERF_CNT_W-1:0] s;
    s = `PERF_CNT_ZERO;
    unique case (src)
      SRC_DISABLED: s = `PERF_CNT_ZERO;
      SRC_ELAPSED: s = `PERF_ONE_STEP;
      SRC_EXEC_STATES: s = ev.exec_state ? `PERF_ONE_STEP : s;
      SRC_BRANCH: s = ev.branch_taken ? `PERF_BRANCH_STEP : s;
      SRC_INSTR: s = ev.instr_done ? `PERF_ONE_STEP : s;
      SRC_DSP_INSTR:
        s = (HAS_DSP && ev.dsp_instr_done) ? `PERF_ONE_STEP : s;
      SRC_INSTR_DATA_CONFLICT:
        s = ev.instr_data_conflict ? `PERF_ONE_STEP : s;
      SRC_OTHER_CONFLICT: s = ev.other_conflict ? `PERF_ONE_STEP : s;
      SRC_EXCEPTION: s = ev.exception_taken ? `PERF_ONE_STEP : s;
      SRC_DATA_TLB_MISS:
        s = (HAS_MMU && ev.data_tlb_miss) ? `PERF_ONE_STEP : s;
      default: s = `PERF_CNT_ZERO;
    endcase
    return s;
  endfunction : step_of

  always_comb begin
    any_enabled = 1'b0;
    for (int i = 0; i < `PERF_CHANNELS; i++) begin
      any_enabled = any_enabled | (source[i] != SRC_DISABLED);
    end
  end

  // Range mode with no channel selected is refused
  assign setup_ok = (mode == MODE_NORMAL) || any_enabled;

  assign start_hit = (active_mode == MODE_ONE_TO_TWO) ? cond_one_match :
    (active_mode == MODE_TWO_TO_ONE) ? cond_two_match :
    (prog_running && !break_hit);
  assign end_hit = (active_mode == MODE_ONE_TO_TWO) ? cond_two_match :
    (active_mode == MODE_TWO_TO_ONE) ? cond_one_match :
    (break_hit || !prog_running);

  // Start while open or end while closed leaves the window as it is
  assign next_window = !armed ? 1'b0 :
    window ? !end_hit : start_hit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_mode <= MODE_NORMAL;
      armed <= 1'b0;
      setup_error <= 1'b0;
    end else if (apply_setup) begin
      active_mode <= mode;
      armed <= setup_ok;
      setup_error <= !setup_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `PERF_CHANNELS; i++) begin
      if (sys_rst) begin
        active_src[i] <= SRC_DISABLED;
      end else if (apply_setup && setup_ok) begin
        active_src[i] <= source[i];
      end
    end
  end

  // Window shuts one edge late, so the end-match cycle still counts
  always_ff @(posedge ref_clk) begin
    if (sys_rst || apply_setup) begin
      window <= 1'b0;
    end else begin
      window <= next_window;
    end
  end

  assign measuring = window;

  // One shared window feeds every channel
  generate
    for (genvar g = 0; g < `PERF_CHANNELS; g++) begin : g_chan
      perf_chan_if link ();
      assign link.window = window;
      assign link.clear = init_request || apply_setup;
      assign link.step = step_of(active_src[g], cpu_events);
      perf_channel u_chan (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .port(link.chan)
      );
      assign result[g] = link.count;
      assign overflow[g] = link.overflow;
    end
  endgenerate

  range_open_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!window && armed && active_mode == MODE_ONE_TO_TWO
      && cond_one_match && !apply_setup) |=> window)
    else $error("one-to-two window did not open");

  range_stop_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_mode == MODE_ONE_TO_TWO && cond_two_match
      && !apply_setup) |=> !window)
    else $error("one-to-two window did not close");

  start_ignored_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_mode == MODE_ONE_TO_TWO && cond_one_match
      && !cond_two_match && !apply_setup) |=> window)
    else $error("repeated start closed window");

  range_rev_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!window && armed && active_mode == MODE_TWO_TO_ONE
      && cond_two_match && !apply_setup) |=> window)
    else $error("two-to-one window did not open");

  rev_stop_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_mode == MODE_TWO_TO_ONE && cond_one_match
      && !apply_setup) |=> !window)
    else $error("two-to-one window did not close");

  end_ignored_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!window && active_mode == MODE_TWO_TO_ONE && cond_one_match
      && !cond_two_match && !apply_setup) |=> !window)
    else $error("end match opened idle window");

  normal_start_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!window && armed && active_mode == MODE_NORMAL && prog_running
      && !break_hit && !apply_setup) |=> window)
    else $error("program run did not open window");

  normal_stop_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (active_mode == MODE_NORMAL && break_hit && !apply_setup)
      |=> !window)
    else $error("break did not close window");

  empty_setup_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (apply_setup && mode != MODE_NORMAL && !any_enabled)
      |=> (setup_error && !armed) ##1 !window)
    else $error("empty range setup accepted");

  error_clear_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (apply_setup && (mode == MODE_NORMAL || any_enabled))
      |=> !setup_error)
    else $error("valid setup flagged as error");

  setup_clear_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    apply_setup |=> (!window && result[0] == `PERF_CNT_ZERO))
    else $error("setup did not restart");

  branch_step_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_src[0] == SRC_BRANCH && cpu_events.branch_taken
      && !init_request && !apply_setup && !overflow[0]
      && result[0] < 32'hFFFF_FFF0)
      |=> result[0] == $past(result[0]) + `PERF_BRANCH_STEP)
    else $error("branch step not two");

  no_dsp_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_src[3] == SRC_DSP_INSTR && !init_request
      && !apply_setup && !(HAS_DSP && cpu_events.dsp_instr_done))
      |=> $stable(result[3]))
    else $error("dsp source counted without event");

  conflict_split_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_src[2] == SRC_OTHER_CONFLICT && !init_request
      && !apply_setup && !cpu_events.other_conflict)
      |=> $stable(result[2]))
    else $error("other conflict counted wrong event");

  no_mmu_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_src[2] == SRC_DATA_TLB_MISS && !init_request
      && !apply_setup && !(HAS_MMU && cpu_events.data_tlb_miss))
      |=> $stable(result[2]))
    else $error("tlb source counted without event");

  init_clear_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    init_request |=> (result[2] == `PERF_CNT_ZERO)
      && (result[3] == `PERF_CNT_ZERO))
    else $error("init did not clear");

  elapsed_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (window && active_src[1] == SRC_ELAPSED && !init_request
      && !apply_setup && result[1] != 32'hFFFF_FFFF)
      |=> result[1] == $past(result[1]) + `PERF_ONE_STEP)
    else $error("elapsed time not counting");
endmodule : perf_event_counters
